// [dv/ser_status_properties.sv]
// Port-level checks on the status register set
`timescale 1ns/1ns
`include "ser_defs.vh"
module ser_status_properties (
	input wire clk,
	input wire reset,
	input wire calibration_computing_flag,
	input wire wait_for_trigger_flag,
	input wire constant_voltage_flag,
	input wire constant_current_flag,
	input wire overtemperature_flag,
	input wire cmd_valid,
	input wire [`SER_CMD_W-1:0] cmd_code,
	input wire [`SER_REG_W-1:0] cmd_wdata,
	input wire rsp_valid,
	input wire [`SER_REG_W-1:0] rsp_data,
	input wire cmd_error,
	input wire operation_summary,
	input wire questionable_summary,
	input wire reporting_suppressed
);
	reg [15:0] qmask_reg;
	reg [15:0] omask_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Shadow copies of both enable masks
	always @(posedge clk)
	begin
		if (reset | (cmd_valid & (cmd_code == `SER_CMD_QUES_EN_WR)))
			qmask_reg <= reset ? 16'h0000 : cmd_wdata;
		if (reset | (cmd_valid & (cmd_code == `SER_CMD_OPER_EN_WR)))
			omask_reg <= reset ? 16'h0000 : cmd_wdata & `SER_OPER_VALID_MASK;
	end
	chk_oper_bits: assert property (rsp_valid && $past(cmd_code) == `SER_CMD_OPER_EVENT
		|-> (rsp_data & ~`SER_OPER_VALID_MASK) == 16'h0000) else $error("oper bits");
	chk_ques_bits: assert property (rsp_valid && $past(cmd_code) >= `SER_CMD_QUES_EVENT
		&& $past(cmd_code) <= `SER_CMD_QUES_COND
		|-> (rsp_data & ~`SER_QUES_VALID_MASK) == 16'h0000) else $error("ques bits");
	chk_ques_clear: assert property ((!overtemperature_flag)[*6]
		##0 (cmd_valid && cmd_code == `SER_CMD_QUES_EVENT)
		##2 (cmd_valid && cmd_code == `SER_CMD_QUES_EVENT)
		|=> rsp_data == 16'h0000) else $error("ques not cleared");
	chk_ques_mask: assert property (questionable_summary |-> qmask_reg[3])
		else $error("ques summary unmasked");
	chk_ques_or: assert property (rsp_valid && $past(cmd_code) == `SER_CMD_QUES_EVENT
		|-> $past(questionable_summary) == |(rsp_data & $past(qmask_reg)))
		else $error("ques summary");
	chk_oper_or: assert property (rsp_valid && $past(cmd_code) == `SER_CMD_OPER_EVENT
		|-> $past(operation_summary) == |(rsp_data & $past(omask_reg)))
		else $error("oper summary");
	chk_mask_read: assert property (rsp_valid && $past(cmd_code) == `SER_CMD_QUES_EN_RD
		|-> rsp_data == $past(qmask_reg)) else $error("mask readback");
	chk_preset_flag: assert property (cmd_valid && cmd_code == `SER_CMD_PRESET
		|=> reporting_suppressed) else $error("preset ignored");
	chk_preset_cond: assert property (rsp_valid && $past(reporting_suppressed)
		&& ($past(cmd_code) == `SER_CMD_OPER_COND || $past(cmd_code) == `SER_CMD_QUES_COND)
		|-> rsp_data == 16'h0000) else $error("condition after preset");
endmodule // ser_status_properties

// [dv/testbench.sv]
// Self-checking bench for the status register set
`timescale 1ns/1ns
`include "ser_defs.vh"
module testbench;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg [4:0] pin = 5'h00;
	reg cmd_valid = 1'b0;
	reg [3:0] cmd_code = 4'h0;
	reg [15:0] cmd_wdata = 16'h0000;
	wire rsp_valid;
	wire [15:0] rsp_data;
	wire cmd_error;
	wire operation_summary;
	wire questionable_summary;
	wire reporting_suppressed;
	reg [15:0] rd;
	integer err_total = 0;
	integer compares = 0;
	// Clock at 10 MHz
	always #50 clk = ~clk;
	ser_status_regs i_ser_status_regs (.clk(clk), .reset(reset),
		.calibration_computing_flag(pin[0]), .wait_for_trigger_flag(pin[1]),
		.constant_voltage_flag(pin[2]), .constant_current_flag(pin[3]),
		.overtemperature_flag(pin[4]), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.cmd_error(cmd_error), .operation_summary(operation_summary),
		.questionable_summary(questionable_summary),
		.reporting_suppressed(reporting_suppressed));
	// Compare one data word
	task chk(input [15:0] got, input [15:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Compare one status flag
	task chk_flag(input got, input exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	end
	endtask
	// One command, answer taken at the falling edge after it is dropped
	task cmd(input [3:0] c, input [15:0] w);
	begin
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_wdata <= w;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		rd = rsp_data;
		chk_flag(rsp_valid, 1'b1);
	end
	endtask
	// New pin levels, then time to pass the synchroniser; ends off the edge
	task set_pins(input [4:0] v);
	begin
		@(posedge clk);
		pin <= v;
		repeat (8) @(posedge clk);
		@(negedge clk);
	end
	endtask
	task stop_test;
	begin
		$display("Mismatches %0d, comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// Reset values and operation events
	task t_oper;
	begin
		cmd(`SER_CMD_QUES_EN_RD, 16'h0000);
		chk(rd, 16'h0000);
		cmd(`SER_CMD_OPER_EN_WR, 16'hffff);
		cmd(`SER_CMD_OPER_EN_RD, 16'h0000);
		chk(rd, 16'h0521);
		set_pins(5'h0f);
		cmd(`SER_CMD_OPER_COND, 16'h0000);
		chk(rd, 16'h0521);
		chk_flag(operation_summary, 1'b1);
		set_pins(5'h00);
		cmd(`SER_CMD_OPER_EVENT, 16'h0000);
		chk(rd, 16'h0521);
		cmd(`SER_CMD_OPER_EVENT, 16'h0000);
		chk(rd, 16'h0000);
		chk_flag(operation_summary, 1'b0);
	end
	endtask
	// Questionable mask, live condition and latch
	task t_ques;
	begin
		cmd(`SER_CMD_QUES_EN_WR, 16'h0003);
		cmd(`SER_CMD_QUES_EN_RD, 16'h0000);
		chk(rd, 16'h0003);
		set_pins(5'h10);
		chk_flag(questionable_summary, 1'b0);
		cmd(`SER_CMD_QUES_EN_WR, 16'h0008);
		chk_flag(questionable_summary, 1'b1);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0008);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0000);
		cmd(`SER_CMD_QUES_COND, 16'h0000);
		chk(rd, 16'h0008);
		set_pins(5'h00);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0000);
		cmd(`SER_CMD_QUES_COND, 16'h0000);
		chk(rd, 16'h0000);
	end
	endtask
	// Preset blanks conditions; unknown code refused
	task t_preset;
	begin
		set_pins(5'h1f);
		cmd(`SER_CMD_PRESET, 16'h0000);
		chk_flag(reporting_suppressed, 1'b1);
		cmd(`SER_CMD_OPER_COND, 16'h0000);
		chk(rd, 16'h0000);
		cmd(`SER_CMD_QUES_COND, 16'h0000);
		chk(rd, 16'h0000);
		// Latch from before the preset is kept, no new event while suppressed
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0008);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0000);
		// Mask write ends suppression; live condition gives a fresh event
		cmd(`SER_CMD_QUES_EN_WR, 16'h0008);
		chk_flag(reporting_suppressed, 1'b0);
		chk_flag(questionable_summary, 1'b1);
		cmd(`SER_CMD_QUES_COND, 16'h0000);
		chk(rd, 16'h0008);
		cmd(`SER_CMD_QUES_EVENT, 16'h0000);
		chk(rd, 16'h0008);
		cmd(4'hf, 16'hffff);
		chk_flag(cmd_error, 1'b1);
		chk(rd, 16'h0000);
	end
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_oper;
		t_ques;
		t_preset;
		stop_test;
	end
	// Watchdog
	initial
	begin
		#2000000;
		err_total = err_total + 1;
		stop_test;
	end
endmodule // testbench
bind ser_status_regs ser_status_properties i_ser_status_properties (.clk(clk), .reset(reset),
	.calibration_computing_flag(calibration_computing_flag),
	.wait_for_trigger_flag(wait_for_trigger_flag), .constant_voltage_flag(constant_voltage_flag),
	.constant_current_flag(constant_current_flag), .overtemperature_flag(overtemperature_flag),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
	.rsp_data(rsp_data), .cmd_error(cmd_error), .operation_summary(operation_summary),
	.questionable_summary(questionable_summary), .reporting_suppressed(reporting_suppressed));

// [inc/ser_defs.vh]
// Constants for the status event reporting register set
`ifndef SER_DEFS_VH
`define SER_DEFS_VH

// Register width
`define SER_REG_W 16

// Operation register bit positions
`define SER_OPER_CAL_BIT 0
`define SER_OPER_TRIG_BIT 5
`define SER_OPER_VOLT_BIT 8
`define SER_OPER_CURR_BIT 10
// Bits 0, 5, 8 and 10: largest readable value 1313
`define SER_OPER_VALID_MASK 16'h0521

// Questionable register bit positions
`define SER_QUES_TEMP_BIT 3
`define SER_QUES_VALID_MASK 16'h0008

// Status byte summary bit positions
`define SER_STB_QUES_BIT 3
`define SER_STB_OPER_BIT 7

// Reset values
`define SER_RESET_REG 16'h0000
`define SER_RESET_FLAGS 5'h00

// Synchronised flag vector layout
`define SER_FLAG_W 5
`define SER_FLAG_CAL 0
`define SER_FLAG_TRIG 1
`define SER_FLAG_VOLT 2
`define SER_FLAG_CURR 3
`define SER_FLAG_TEMP 4

// Command codes on the command port
`define SER_CMD_W 4
`define SER_CMD_OPER_COND 4'h1
`define SER_CMD_OPER_EVENT 4'h2
`define SER_CMD_OPER_EN_WR 4'h3
`define SER_CMD_OPER_EN_RD 4'h4
`define SER_CMD_PRESET 4'h5
`define SER_CMD_QUES_EVENT 4'h6
`define SER_CMD_QUES_COND 4'h7
`define SER_CMD_QUES_EN_WR 4'h8
`define SER_CMD_QUES_EN_RD 4'h9

`endif

// [verilog/ser_status_regs.v]
// Operation and questionable condition, event and enable registers
// Operation and questionable
// - Operation events latch until read, read clears
// - Operation event reads only bits 0,5,8,10
// - Preset forces both condition registers to zero
// - Questionable events latch, read-only, cleared by read
// - Questionable condition and event 16 bits, only bit 3; enable keeps all 16
// - Questionable condition shows live state, unlatched
// - Questionable enable masks bits into summary
// - Questionable summary is OR of enabled events
// - Questionable enable reads back last written mask
// - Cal 0, trigger 5, voltage 8, current 10
// - Operation summary is OR of enabled events
`timescale 1ns/1ns
`include "ser_defs.vh"

module ser_status_regs (
	input wire clk,
	input wire reset,
	input wire calibration_computing_flag,
	input wire wait_for_trigger_flag,
	input wire constant_voltage_flag,
	input wire constant_current_flag,
	input wire overtemperature_flag,
	input wire cmd_valid,
	input wire [`SER_CMD_W-1:0] cmd_code,
	input wire [`SER_REG_W-1:0] cmd_wdata,
	output reg rsp_valid,
	output reg [`SER_REG_W-1:0] rsp_data,
	output reg cmd_error,
	output reg operation_summary,
	output reg questionable_summary,
	output reg reporting_suppressed
);

	// Rising edge of a condition vector
	function [`SER_REG_W-1:0] rise_of;
		input [`SER_REG_W-1:0] now_val;
		input [`SER_REG_W-1:0] old_val;
		begin
			rise_of = now_val & ~old_val;
		end
	endfunction

	// Summary: OR of enabled event bits
	function summary_of;
		input [`SER_REG_W-1:0] events;
		input [`SER_REG_W-1:0] mask;
		begin
			summary_of = |(events & mask);
		end
	endfunction

	wire [`SER_FLAG_W-1:0] flags_sync;
	reg [`SER_REG_W-1:0] oper_cond_reg;
	reg [`SER_REG_W-1:0] oper_cond_next;
	reg [`SER_REG_W-1:0] oper_event_reg;
	reg [`SER_REG_W-1:0] oper_event_next;
	reg [`SER_REG_W-1:0] oper_enable_reg;
	reg [`SER_REG_W-1:0] oper_enable_next;
	reg [`SER_REG_W-1:0] questionable_live_condition_reg;
	reg [`SER_REG_W-1:0] ques_cond_next;
	reg [`SER_REG_W-1:0] questionable_event_latch_reg;
	reg [`SER_REG_W-1:0] ques_event_next;
	reg [`SER_REG_W-1:0] questionable_event_mask_reg;
	reg [`SER_REG_W-1:0] ques_mask_next;
	reg suppress_next;
	reg [`SER_REG_W-1:0] oper_raw;
	reg [`SER_REG_W-1:0] ques_raw;
	reg [`SER_REG_W-1:0] rd_data_next;
	reg known_cmd;
	reg clr_oper_event;
	reg clr_ques_event;
	reg wr_oper_enable;
	reg wr_ques_mask;
	reg status_preset_command;

	// Pin-side flags pass the three-stage synchroniser
	ser_sync u_sync (
		.clk(clk),
		.reset(reset),
		.sync_in({overtemperature_flag, constant_current_flag, constant_voltage_flag,
			wait_for_trigger_flag, calibration_computing_flag}),
		.sync_out(flags_sync)
	);

	// Command decode and read data selection
	always @*
	begin
		rd_data_next = `SER_RESET_REG;
		known_cmd = 1'b1;
		clr_oper_event = 1'b0;
		clr_ques_event = 1'b0;
		wr_oper_enable = 1'b0;
		wr_ques_mask = 1'b0;
		status_preset_command = 1'b0;
		if (cmd_valid)
		begin
			case (cmd_code)
				`SER_CMD_OPER_COND: rd_data_next = oper_cond_reg;
				`SER_CMD_OPER_EVENT:
				begin
					rd_data_next = oper_event_reg & `SER_OPER_VALID_MASK;
					clr_oper_event = 1'b1;
				end
				`SER_CMD_OPER_EN_WR: wr_oper_enable = 1'b1;
				`SER_CMD_OPER_EN_RD: rd_data_next = oper_enable_reg;
				`SER_CMD_PRESET: status_preset_command = 1'b1;
				`SER_CMD_QUES_EVENT:
				begin
					rd_data_next = questionable_event_latch_reg;
					clr_ques_event = 1'b1;
				end
				`SER_CMD_QUES_COND: rd_data_next = questionable_live_condition_reg;
				`SER_CMD_QUES_EN_WR: wr_ques_mask = 1'b1;
				`SER_CMD_QUES_EN_RD: rd_data_next = questionable_event_mask_reg;
				default: known_cmd = 1'b0;
			endcase
		end
	end

	// Live condition vectors from the synchronised flags
	always @*
	begin
		oper_raw = `SER_RESET_REG;
		oper_raw[`SER_OPER_CAL_BIT] = flags_sync[`SER_FLAG_CAL];
		oper_raw[`SER_OPER_TRIG_BIT] = flags_sync[`SER_FLAG_TRIG];
		oper_raw[`SER_OPER_VOLT_BIT] = flags_sync[`SER_FLAG_VOLT];
		oper_raw[`SER_OPER_CURR_BIT] = flags_sync[`SER_FLAG_CURR];
		ques_raw = `SER_RESET_REG;
		ques_raw[`SER_QUES_TEMP_BIT] = flags_sync[`SER_FLAG_TEMP];
	end

	// Next state of conditions, events and masks
	always @*
	begin
		// Preset holds reporting off until an enable register is written
		suppress_next = status_preset_command
			| (reporting_suppressed & ~wr_oper_enable & ~wr_ques_mask);
		oper_cond_next = suppress_next ? `SER_RESET_REG : oper_raw;
		ques_cond_next = suppress_next ? `SER_RESET_REG : ques_raw;
		// New edge wins over a clearing read in the same cycle
		oper_event_next = (clr_oper_event ? `SER_RESET_REG : oper_event_reg)
			| rise_of(oper_cond_next, oper_cond_reg);
		ques_event_next = (clr_ques_event ? `SER_RESET_REG : questionable_event_latch_reg)
			| rise_of(ques_cond_next, questionable_live_condition_reg);
		oper_enable_next = wr_oper_enable ? (cmd_wdata & `SER_OPER_VALID_MASK)
			: oper_enable_reg;
		ques_mask_next = wr_ques_mask ? cmd_wdata : questionable_event_mask_reg;
	end

	// Register state and registered outputs
	always @(posedge clk)
	begin
		if (reset)
		begin
			oper_cond_reg <= `SER_RESET_REG;
			oper_event_reg <= `SER_RESET_REG;
			oper_enable_reg <= `SER_RESET_REG;
			questionable_live_condition_reg <= `SER_RESET_REG;
			questionable_event_latch_reg <= `SER_RESET_REG;
			questionable_event_mask_reg <= `SER_RESET_REG;
			reporting_suppressed <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= `SER_RESET_REG;
			cmd_error <= 1'b0;
			operation_summary <= 1'b0;
			questionable_summary <= 1'b0;
		end
		else
		begin
			oper_cond_reg <= oper_cond_next;
			oper_event_reg <= oper_event_next;
			oper_enable_reg <= oper_enable_next;
			questionable_live_condition_reg <= ques_cond_next;
			questionable_event_latch_reg <= ques_event_next;
			questionable_event_mask_reg <= ques_mask_next;
			reporting_suppressed <= suppress_next;
			// Answer one cycle after each command
			rsp_valid <= cmd_valid;
			rsp_data <= rd_data_next;
			cmd_error <= cmd_valid & ~known_cmd;
			// Summaries track the event state being stored
			operation_summary <= summary_of(oper_event_next, oper_enable_next);
			questionable_summary <= summary_of(ques_event_next, ques_mask_next);
		end
	end

endmodule // ser_status_regs

// [verilog/ser_sync.v]
// Three-stage synchroniser for the asynchronous condition inputs
`timescale 1ns/1ns
`include "ser_defs.vh"

module ser_sync (
	input wire clk,
	input wire reset,
	input wire [`SER_FLAG_W-1:0] sync_in,
	output reg [`SER_FLAG_W-1:0] sync_out
);

	reg [`SER_FLAG_W-1:0] stage1_reg;
	reg [`SER_FLAG_W-1:0] stage2_reg;
	reg [`SER_FLAG_W-1:0] stage3_reg;

	// Stage chain; output follows only when stages two and three agree
	always @(posedge clk)
	begin
		if (reset)
		begin
			stage1_reg <= `SER_RESET_FLAGS;
			stage2_reg <= `SER_RESET_FLAGS;
			stage3_reg <= `SER_RESET_FLAGS;
			sync_out <= `SER_RESET_FLAGS;
		end
		else
		begin
			stage1_reg <= sync_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			// Per bit: take the new level once two samples match
			sync_out <= (stage2_reg & ~(stage2_reg ^ stage3_reg))
				| (sync_out & (stage2_reg ^ stage3_reg));
		end
	end

endmodule // ser_sync
